// File: dcpwm_top.sv
// Two channel pulse width modulator with its registers on the external data bus.
`timescale 1ns/1ns
module dcpwm_top (
    // Clock, reset and clock enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // External data space access
    input wire logic [dcpwm_pkg::DCPWM_ADDR_W-1:0] extAddr,
    input wire logic [dcpwm_pkg::DCPWM_DATA_W-1:0] extWrData,
    input wire logic extWrEn,
    input wire logic extRdEn,
    output logic [dcpwm_pkg::DCPWM_DATA_W-1:0] extRdData,
    // Alternate function pins
    output logic portThreeBitSixOut,
    output logic portThreeBitSixOe,
    output logic portTwoBitZeroOut,
    output logic portTwoBitZeroOe,
    // Shared low voltage reset settings
    output logic [dcpwm_pkg::DCPWM_LVR_W-1:0] lowVoltResetCfg
);
    import dcpwm_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [DCPWM_DATA_W-1:0] channelControl_reg;
    logic [DCPWM_LVR_W-1:0] lowVoltReset_reg;
    logic wideMode_reg;
    logic [DCPWM_DATA_W-1:0] dutyValueOne_reg;
    logic [DCPWM_DATA_W-1:0] dutyValueTwo_reg;
    logic [DCPWM_DATA_W-1:0] extRdData_reg;
    logic [DCPWM_DATA_W-1:0] readMux;
    logic restart_reg;
    logic hitCtrl;
    logic hitDuty1;
    logic hitDuty2;
    logic hitMode;
    logic wrMode;
    logic modeChange;
    logic chanOneOutEnable;
    logic chanTwoOutEnable;
    logic [DCPWM_CNT_W-1:0] dutyOne;
    logic [DCPWM_CNT_W-1:0] dutyTwo;
    logic waveOne;
    logic waveTwo;

    dcpwm_chan_if chanOne ();
    dcpwm_chan_if chanTwo ();

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    assign hitCtrl = extAddr == DCPWM_CTRL_ADDR;
    assign hitDuty1 = extAddr == DCPWM_DUTY1_ADDR;
    assign hitDuty2 = extAddr == DCPWM_DUTY2_ADDR;
    assign hitMode = extAddr == DCPWM_MODE_ADDR;
    assign wrMode = extWrEn && hitMode;
    assign modeChange = wrMode && (extWrData[DCPWM_MODE_BIT] != wideMode_reg);

    // ------------------------------------------------------------------
    // Channel control register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            channelControl_reg <= DCPWM_CTRL_RST;
        end else if (ce && extWrEn && hitCtrl) begin
            channelControl_reg <= extWrData;
        end
    end

    // ------------------------------------------------------------------
    // Width mode register, shared with the low voltage reset settings
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wideMode_reg <= DCPWM_MODE_RST[DCPWM_MODE_BIT];
        end else if (ce && wrMode) begin
            wideMode_reg <= extWrData[DCPWM_MODE_BIT];
        end
    end

    // The upper bits are only stored and passed on; software keeps them intact.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lowVoltReset_reg <= DCPWM_MODE_RST[DCPWM_LVR_MSB:DCPWM_LVR_LSB];
        end else if (ce && wrMode) begin
            lowVoltReset_reg <= extWrData[DCPWM_LVR_MSB:DCPWM_LVR_LSB];
        end
    end

    assign lowVoltResetCfg = lowVoltReset_reg;

    // A width change restarts both channels from a clean period.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            restart_reg <= 1'b0;
        end else if (ce) begin
            restart_reg <= modeChange;
        end
    end

    // ------------------------------------------------------------------
    // Duty registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dutyValueOne_reg <= DCPWM_DUTY_RST;
        end else if (ce && extWrEn && hitDuty1) begin
            dutyValueOne_reg <= extWrData;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dutyValueTwo_reg <= DCPWM_DUTY_RST;
        end else if (ce && extWrEn && hitDuty2) begin
            dutyValueTwo_reg <= extWrData;
        end
    end

    // ------------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------------
    always_comb begin
        readMux = DCPWM_READ_UNMAPPED;
        if (hitCtrl) begin
            readMux = channelControl_reg;
        end else if (hitDuty1) begin
            readMux = dutyValueOne_reg;
        end else if (hitDuty2) begin
            readMux = dutyValueTwo_reg;
        end else if (hitMode) begin
            readMux[DCPWM_LVR_MSB:DCPWM_LVR_LSB] = lowVoltReset_reg;
            readMux[DCPWM_MODE_BIT] = wideMode_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            extRdData_reg <= DCPWM_READ_UNMAPPED;
        end else if (ce && extRdEn) begin
            extRdData_reg <= readMux;
        end
    end

    assign extRdData = extRdData_reg;

    // ------------------------------------------------------------------
    // Channel setup
    // ------------------------------------------------------------------
    assign chanOneOutEnable = channelControl_reg[DCPWM_CH1_EN_BIT];
    assign chanTwoOutEnable = channelControl_reg[DCPWM_CH2_EN_BIT];

    assign chanOne.enable = chanOneOutEnable;
    assign chanOne.restart = restart_reg;
    assign chanOne.prescaleSel = channelControl_reg[DCPWM_CH1_PS_MSB:DCPWM_CH1_PS_LSB];
    // Channel two has no waveform of its own in wide mode.
    assign chanTwo.enable = chanTwoOutEnable && !wideMode_reg;
    assign chanTwo.restart = restart_reg;
    assign chanTwo.prescaleSel = channelControl_reg[DCPWM_CH2_PS_MSB:DCPWM_CH2_PS_LSB];

    // Wide mode joins both bytes with channel two as the high byte.
    assign dutyOne = wideMode_reg ? {dutyValueTwo_reg, dutyValueOne_reg}
                                  : {DCPWM_ZERO_BYTE, dutyValueOne_reg};
    assign dutyTwo = {DCPWM_ZERO_BYTE, dutyValueTwo_reg};

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    dcpwm_prescaler #(.PS_CNT_W(DCPWM_PS_CNT_W)) chanOneScaler (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .chan(chanOne.scaler)
    );

    dcpwm_counter #(.CNT_W(DCPWM_CNT_W)) chanOneCounter (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .chan(chanOne.counter),
        .wideMode(wideMode_reg),
        .duty(dutyOne),
        .pwmOut(waveOne)
    );

    dcpwm_prescaler #(.PS_CNT_W(DCPWM_PS_CNT_W)) chanTwoScaler (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .chan(chanTwo.scaler)
    );

    dcpwm_counter #(.CNT_W(DCPWM_CNT_W)) chanTwoCounter (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .chan(chanTwo.counter),
        .wideMode(1'b0),
        .duty(dutyTwo),
        .pwmOut(waveTwo)
    );

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    // A disabled channel releases its pin; an enabled one drives it.
    assign portThreeBitSixOut = waveOne;
    assign portThreeBitSixOe = chanOneOutEnable;
    assign portTwoBitZeroOut = waveTwo;
    assign portTwoBitZeroOe = chanTwoOutEnable;
endmodule

// File: dcpwm_pkg.sv
// Constants, field layout and types shared by the dual channel pulse width modulator.
package dcpwm_pkg;

    // ------------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------------
    localparam int DCPWM_ADDR_W = 16;
    localparam int DCPWM_DATA_W = 8;
    localparam logic [15:0] DCPWM_CTRL_ADDR = 16'h8025;
    localparam logic [15:0] DCPWM_DUTY1_ADDR = 16'h8026;
    localparam logic [15:0] DCPWM_DUTY2_ADDR = 16'h8027;
    localparam logic [15:0] DCPWM_MODE_ADDR = 16'h802b;
    localparam logic [7:0] DCPWM_CTRL_RST = 8'h00;
    localparam logic [7:0] DCPWM_MODE_RST = 8'h00;
    localparam logic [7:0] DCPWM_DUTY_RST = 8'h00;
    localparam logic [7:0] DCPWM_READ_UNMAPPED = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int DCPWM_CH2_EN_BIT = 7;
    localparam int DCPWM_CH2_PS_MSB = 6;
    localparam int DCPWM_CH2_PS_LSB = 4;
    localparam int DCPWM_CH1_EN_BIT = 3;
    localparam int DCPWM_CH1_PS_MSB = 2;
    localparam int DCPWM_CH1_PS_LSB = 0;
    localparam int DCPWM_PS_W = 3;
    localparam int DCPWM_MODE_BIT = 0;
    localparam int DCPWM_LVR_MSB = 7;
    localparam int DCPWM_LVR_LSB = 6;
    localparam int DCPWM_LVR_W = 2;

    // ------------------------------------------------------------------
    // Counter widths and wrap points
    // ------------------------------------------------------------------
    localparam int DCPWM_CNT_W = 16;
    localparam int DCPWM_PS_CNT_W = 8;
    localparam logic [15:0] DCPWM_WRAP8 = 16'h00ff;
    localparam logic [15:0] DCPWM_WRAP16 = 16'hffff;
    localparam logic [7:0] DCPWM_ZERO_BYTE = 8'h00;

    typedef enum logic [0:0] {DCPWM_IDLE, DCPWM_RUN} dcpwm_state_t;

endpackage

// File: dcpwm_chan_if.sv
// Interface joining a channel's control, its prescaler and its counter.
`timescale 1ns/1ns
interface dcpwm_chan_if;
    import dcpwm_pkg::*;
    logic enable;
    logic restart;
    logic [DCPWM_PS_W-1:0] prescaleSel;
    logic tick;
    modport ctrl(output enable, output restart, output prescaleSel);
    modport scaler(input enable, input restart, input prescaleSel, output tick);
    modport counter(input enable, input restart, input tick);
endinterface

// File: dcpwm_prescaler.sv
// Power of two prescaler that turns the system clock into counting ticks.
`timescale 1ns/1ns
module dcpwm_prescaler #(
    parameter int PS_CNT_W = 8
) (
    // Clock and control
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Channel link
    dcpwm_chan_if.scaler chan
);
    import dcpwm_pkg::*;

    logic [PS_CNT_W-1:0] divCount_reg;
    logic [PS_CNT_W:0] ratio;
    logic [PS_CNT_W-1:0] lastCount;
    logic atLast;

    // Ratio is two shifted by the select code.
    always_comb begin
        ratio = (PS_CNT_W+1)'(2) << chan.prescaleSel;
        lastCount = PS_CNT_W'(ratio - (PS_CNT_W+1)'(1));
    end

    // A select lowered below the running count ends the cycle at once.
    assign atLast = divCount_reg >= lastCount;
    assign chan.tick = ce && chan.enable && !chan.restart && atLast;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divCount_reg <= '0;
        end else if (ce) begin
            if (!chan.enable || chan.restart || atLast) begin
                divCount_reg <= '0;
            end else begin
                divCount_reg <= divCount_reg + PS_CNT_W'(1);
            end
        end
    end
endmodule

// File: dcpwm_counter.sv
// Period counter and duty comparator of one modulator channel.
`timescale 1ns/1ns
module dcpwm_counter #(
    parameter int CNT_W = 16
) (
    // Clock and control
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Channel link
    dcpwm_chan_if.counter chan,
    // Setup
    input wire logic wideMode,
    input wire logic [CNT_W-1:0] duty,
    // Waveform
    output logic pwmOut
);
    import dcpwm_pkg::*;

    dcpwm_state_t state_reg;
    dcpwm_state_t state_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] shadowDuty_reg;
    logic [CNT_W-1:0] wrapValue;
    logic atWrap;
    logic pwmOut_reg;

    // --------------------------------------------------------------------
    // Period length
    // --------------------------------------------------------------------
    assign wrapValue = wideMode ? CNT_W'(DCPWM_WRAP16) : CNT_W'(DCPWM_WRAP8);
    assign atWrap = count_reg == wrapValue;

    always_comb begin
        case (state_reg)
            DCPWM_IDLE: state_next = chan.enable ? DCPWM_RUN : DCPWM_IDLE;
            DCPWM_RUN: state_next = chan.enable ? DCPWM_RUN : DCPWM_IDLE;
            default: state_next = DCPWM_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= DCPWM_IDLE;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // --------------------------------------------------------------------
    // Free running counter
    // --------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
        end else if (ce) begin
            if (state_reg != DCPWM_RUN || chan.restart) begin
                count_reg <= '0;
            end else if (chan.tick) begin
                count_reg <= atWrap ? '0 : count_reg + CNT_W'(1);
            end
        end
    end

    // --------------------------------------------------------------------
    // Duty shadow, loaded while stopped or at the end of a period
    // --------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shadowDuty_reg <= '0;
        end else if (ce) begin
            if (state_reg != DCPWM_RUN || chan.restart || (chan.tick && atWrap)) begin
                shadowDuty_reg <= duty;
            end
        end
    end

    // --------------------------------------------------------------------
    // Compare
    // --------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwmOut_reg <= 1'b0;
        end else if (ce) begin
            // The enable gates the compare, not the state, so the first count lasts a full tick.
            pwmOut_reg <= chan.enable && (count_reg < shadowDuty_reg);
        end
    end

    assign pwmOut = pwmOut_reg;
endmodule

// File: dcpwm_monitor.sv
// Concurrent checks on the ports of the dual channel modulator.
`timescale 1ns/1ns
module dcpwm_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Register access
    input wire logic [dcpwm_pkg::DCPWM_ADDR_W-1:0] extAddr,
    input wire logic [dcpwm_pkg::DCPWM_DATA_W-1:0] extWrData,
    input wire logic extWrEn,
    input wire logic extRdEn,
    input wire logic [dcpwm_pkg::DCPWM_DATA_W-1:0] extRdData,
    // Pins
    input wire logic portThreeBitSixOut,
    input wire logic portThreeBitSixOe,
    input wire logic portTwoBitZeroOut,
    input wire logic portTwoBitZeroOe,
    input wire logic [dcpwm_pkg::DCPWM_LVR_W-1:0] lowVoltResetCfg
);
    import dcpwm_pkg::*;
    logic wrCtrl;
    logic wrMode;
    logic rdTake;
    logic mapped;
    logic wideReg;
    assign wrCtrl = ce && extWrEn && extAddr == DCPWM_CTRL_ADDR;
    assign wrMode = ce && extWrEn && extAddr == DCPWM_MODE_ADDR;
    assign rdTake = ce && extRdEn && !extWrEn;
    assign mapped = extAddr inside {DCPWM_CTRL_ADDR, DCPWM_DUTY1_ADDR, DCPWM_DUTY2_ADDR,
        DCPWM_MODE_ADDR};

    // Width mode as last written, to know when channel two must stay quiet.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wideReg <= 1'b0;
        end else if (wrMode) begin
            wideReg <= extWrData[DCPWM_MODE_BIT];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_ch1Enable;
        wrCtrl |=> portThreeBitSixOe == $past(extWrData[DCPWM_CH1_EN_BIT]);
    endproperty
    a_ch1Enable: assert property (p_ch1Enable)
        else $error("channel one enable does not follow control write");
    property p_ch2Enable;
        wrCtrl |=> portTwoBitZeroOe == $past(extWrData[DCPWM_CH2_EN_BIT]);
    endproperty
    a_ch2Enable: assert property (p_ch2Enable)
        else $error("channel two enable does not follow control write");
    property p_modeShare;
        wrMode |=> lowVoltResetCfg == $past(extWrData[DCPWM_LVR_MSB:DCPWM_LVR_LSB]);
    endproperty
    a_modeShare: assert property (p_modeShare)
        else $error("low voltage settings not taken from mode write");
    property p_rdHold;
        !(ce && extRdEn) |=> $stable(extRdData);
    endproperty
    a_rdHold: assert property (p_rdHold)
        else $error("read data changed without a read");
    property p_unmapped;
        rdTake && !mapped |=> extRdData == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned nonzero");
    property p_modeRead;
        rdTake && extAddr == DCPWM_MODE_ADDR |=> extRdData[5:1] == 5'h00;
    endproperty
    a_modeRead: assert property (p_modeRead)
        else $error("unused mode bits read nonzero");
    property p_quietOff;
        !portThreeBitSixOe [*3] |-> !portThreeBitSixOut;
    endproperty
    a_quietOff: assert property (p_quietOff)
        else $error("disabled channel one still pulses");
    property p_riseEnabled;
        $rose(portTwoBitZeroOut) |-> portTwoBitZeroOe;
    endproperty
    a_riseEnabled: assert property (p_riseEnabled)
        else $error("channel two pulse while disabled");
    property p_wideQuiet;
        wideReg [*4] |-> !portTwoBitZeroOut;
    endproperty
    a_wideQuiet: assert property (p_wideQuiet)
        else $error("channel two pulses in wide mode");

    c_ch1Pulse: cover property ($rose(portThreeBitSixOut));
    c_ch2Pulse: cover property ($rose(portTwoBitZeroOut));
    c_unmapped: cover property (rdTake && !mapped);
    c_widePulse: cover property (wideReg && $rose(portThreeBitSixOut));
endmodule

// File: tb_dcpwm_top.sv
// Self-checking bench for the dual channel modulator.
`timescale 1ns/1ns
module tb_dcpwm_top;
    import dcpwm_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [15:0] extAddr = 16'h0000;
    logic [7:0] extWrData = 8'h00;
    logic extWrEn = 1'b0;
    logic extRdEn = 1'b0;
    logic [7:0] extRdData;
    logic p36, p36Oe, p20, p20Oe;
    logic [1:0] low_volt_reset;
    int failCount = 0;
    int totalChecks = 0;
    int cyc = 0;
    int wt, hi, per;
    logic [2:0] s3;
    logic ch;

    dcpwm_top dut (.clk(clk), .rstn(rstn), .ce(ce), .extAddr(extAddr), .extWrData(extWrData),
        .extWrEn(extWrEn), .extRdEn(extRdEn), .extRdData(extRdData),
        .portThreeBitSixOut(p36), .portThreeBitSixOe(p36Oe), .portTwoBitZeroOut(p20),
        .portTwoBitZeroOe(p20Oe), .lowVoltResetCfg(low_volt_reset));

    always #5 clk = ~clk;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task endSim;
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failCount++;
            endSim();
        end
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        extAddr <= a;
        extWrData <= d;
        extWrEn <= 1'b1;
        @(posedge clk);
        extWrEn <= 1'b0;
    endtask

    task rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        extAddr <= a;
        extRdEn <= 1'b1;
        @(posedge clk);
        extRdEn <= 1'b0;
        #1 chk("read data", {24'h0, extRdData}, {24'h0, exp});
    endtask

    function automatic logic pin(input logic c);
        return c ? p20 : p36;
    endfunction

    // The period is only followed when asked, as the slow prescales would take too long.
    task automatic meas(input logic c, input bit full, output int w, output int h, output int p);
        w = 0;
        h = 0;
        while (pin(c) !== 1'b1) begin
            @(posedge clk);
            w++;
        end
        while (pin(c) === 1'b1) begin
            @(posedge clk);
            h++;
        end
        p = h;
        while (full && pin(c) !== 1'b1) begin
            @(posedge clk);
            p++;
        end
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rd(DCPWM_CTRL_ADDR, 8'h00);
        rd(DCPWM_DUTY1_ADDR, 8'h00);
        rd(DCPWM_DUTY2_ADDR, 8'h00);
        rd(DCPWM_MODE_ADDR, 8'h00);
        chk("enables", {30'h0, p20Oe, p36Oe}, 32'h0);
        wr(DCPWM_CTRL_ADDR, 8'h5a);
        rd(DCPWM_CTRL_ADDR, 8'h5a);
        wr(DCPWM_CTRL_ADDR, 8'ha5);
        rd(DCPWM_CTRL_ADDR, 8'ha5);
        ce <= 1'b0;
        wr(DCPWM_CTRL_ADDR, 8'h00);
        ce <= 1'b1;
        rd(DCPWM_CTRL_ADDR, 8'ha5);
        wr(DCPWM_MODE_ADDR, 8'hff);
        rd(DCPWM_MODE_ADDR, 8'hc1);
        chk("shared bits", {30'h0, low_volt_reset}, 32'h3);
        wr(DCPWM_MODE_ADDR, 8'hc0);
        wr(16'h8030, 8'hff);
        rd(16'h8030, 8'h00);
        wr(DCPWM_CTRL_ADDR, 8'h00);
        wr(DCPWM_DUTY1_ADDR, 8'h01);
        wr(DCPWM_DUTY2_ADDR, 8'h02);
        for (int s = 0; s < 8; s++) begin
            s3 = 3'(s);
            ch = s3[0];
            wr(DCPWM_CTRL_ADDR, ch ? {1'b1, s3, 4'h0} : {4'h0, 1'b1, s3});
            meas(ch, s < 2, wt, hi, per);
            chk("pulse", 32'(hi), (ch ? 32'd2 : 32'd1) << (s + 1));
            if (s < 2) begin
                chk("period", 32'(per), 32'd256 << (s + 1));
            end
            chk("enables", {30'h0, p20Oe, p36Oe}, ch ? 32'h2 : 32'h1);
            wr(DCPWM_CTRL_ADDR, 8'h00);
        end
        wr(DCPWM_DUTY1_ADDR, 8'h04);
        wr(DCPWM_CTRL_ADDR, 8'h08);
        repeat (20) @(posedge clk);
        wr(DCPWM_DUTY1_ADDR, 8'h40);
        meas(1'b0, 1'b0, wt, hi, per);
        chk("late duty", 32'(wt > 400), 32'h1);
        chk("new pulse", 32'(hi), 32'd128);
        wr(DCPWM_CTRL_ADDR, 8'h00);
        wr(DCPWM_DUTY1_ADDR, 8'h00);
        wr(DCPWM_DUTY2_ADDR, 8'h01);
        wr(DCPWM_MODE_ADDR, 8'hc1);
        wr(DCPWM_CTRL_ADDR, 8'h88);
        meas(1'b0, 1'b0, wt, hi, per);
        chk("wide pulse", 32'(hi), 32'd512);
        chk("wide two", {31'h0, p20}, 32'h0);
        chk("wide enables", {30'h0, p20Oe, p36Oe}, 32'h3);
        rd(DCPWM_MODE_ADDR, 8'hc1);
        chk("shared kept", {30'h0, low_volt_reset}, 32'h3);
        endSim();
    end
endmodule

bind dcpwm_top dcpwm_monitor mon (.clk(clk), .rstn(rstn), .ce(ce), .extAddr(extAddr),
    .extWrData(extWrData), .extWrEn(extWrEn), .extRdEn(extRdEn), .extRdData(extRdData),
    .portThreeBitSixOut(portThreeBitSixOut), .portThreeBitSixOe(portThreeBitSixOe),
    .portTwoBitZeroOut(portTwoBitZeroOut), .portTwoBitZeroOe(portTwoBitZeroOe),
    .lowVoltResetCfg(lowVoltResetCfg));
